// file: core/fpcd_regs.svh
// Constants for the coprocessor command decoder: address fields and codes.
// Assumes field bit 0 is the most significant bit, bus bit [31].
`ifndef FPCD_REGS_SVH
`define FPCD_REGS_SVH
`define FPCD_SEG_ID 8'hff
`define FPCD_LOW_FIX 12'hff0
`define FPCD_RSV_ZERO 4'h0
`define FPCD_XFER_WORD 2'b10
`define FPCD_SRC_NONE 2'b00
`define FPCD_SRC_OP2 2'b01
`define FPCD_SRC_OP1 2'b10
`define FPCD_SRC_RSV 2'b11
`define FPCD_FMT_LONG 2'b00
`define FPCD_FMT_SHORT 2'b01
`define FPCD_FMT_CVT 2'b11
`define FPCD_FMT_CVT_LS 2'b10
`define FPCD_GRP_ARITH 2'b01
`define FPCD_GRP_CVT 2'b00
`define FPCD_OP_ADD 4'h0
`define FPCD_OP_COPY 4'h1
`define FPCD_OP_CMP 4'h2
`define FPCD_OP_DIV 4'h8
`define FPCD_OP_ABS 4'hd
`define FPCD_CV_W2L 4'h0
`define FPCD_CV_W2S 4'h1
`define FPCD_CV_L2S 4'h5
`define FPCD_CV_S2L 4'h6
`define FPCD_CV_FLR 4'hf
`define FPCD_EXC_ILLEGAL 3'h7
`define FPCD_EXC_PRIV 3'h7
`endif

// file: core/fpcd_pkg.sv
// Types shared by the command decoder.
// Assumes the constants header is compiled alongside.
package fpcd_pkg;
  typedef enum logic [3:0] {
    FPCD_NOP, FPCD_MAG, FPCD_SUM, FPCD_CMP, FPCD_MOVE, FPCD_QUOT,
    FPCD_WIDEN, FPCD_NARROW, FPCD_I2S, FPCD_I2L, FPCD_FLOOR, FPCD_BAD
  } fpcd_op_t;
  typedef enum logic [1:0] {
    FPCD_IMM_NONE, FPCD_IMM_OP2, FPCD_IMM_OP1
  } fpcd_imm_t;
endpackage

// file: core/fpcd_decoder.sv
// Command decoder for a memory-mapped floating-point coprocessor.
// Assumes one transfer strobe per cycle from the processor channel.
`include "fpcd_regs.svh"

// Functional notes
// - Exception capture holds control byte, bit 7 zero, command bits 8-31.
// - Control bits 2 and 3 equal 10 marks a four-byte transfer.
// - Operand fields index sixteen registers short or eight pairs long.
// - Long operands and results use a 64-bit register pair.
// - Immediate commands take the store data word as operand.
// - Supervisor-only commands from normal state raise exception, do nothing.
// - Immediate magnitude writes first register, result to second.
// - Add with second-operand immediate loads second, sums into second.
// - Long immediate forms write only the even high half of the routed pair.
// - Compare writes no register, sets status bits 21-22, ignores low bits.
// - Short-to-long widens into result pair, source kept.
// - Long-to-short narrows pair into second register, source kept.
// - Integer-to-short converts first register into second.
// - Integer-to-long converts first register into result pair.
// - Conversion immediate form writes first register before converting.
// - Divide puts second over first into second; immediate may be dividend.
// - Floor converts short to integer toward minus infinity into second.
// - Only addresses starting FF are commands; low 24 bits form command.
// - Bits 12-13 route immediate: none, second, first, reserved.
module fpcd_decoder (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Processor channel
  input wire logic xfer_valid_in,
  input wire logic [31:0] addr_in,
  input wire logic [7:0] ctrl_in,
  input wire logic [31:0] data_in,
  // Dispatch
  output logic cmd_valid_out,
  output fpcd_pkg::fpcd_op_t op_out,
  output fpcd_pkg::fpcd_imm_t imm_route_out,
  output logic [31:0] imm_data_out,
  output logic src_long_out,
  output logic dst_long_out,
  output logic [3:0] op1_sel_out,
  output logic [3:0] op2_sel_out,
  output logic [3:0] imm_sel_out,
  output logic imm_wr_out,
  output logic result_wr_out,
  output logic cc_wr_out,
  // Exceptions
  output logic exc_out,
  output logic [2:0] exc_type_out,
  output logic [31:0] exception_capture_reg_out
);
  import fpcd_pkg::*;

  logic is_cmd;
  logic [1:0] src_f;
  logic [1:0] fmt_f;
  logic [3:0] grp_f;
  logic [3:0] opc_f;
  logic [3:0] r1_f;
  logic [3:0] r2_f;
  logic word_xfer;
  logic store_xfer;
  logic priv_ok;
  logic sel_ok;
  logic lng_src;
  logic lng_dst;
  logic legal;
  fpcd_op_t op_nxt;

  // Address fields, bit 0 of the manual is bit 31 here
  assign is_cmd = xfer_valid_in && addr_in[31:24] == `FPCD_SEG_ID;
  assign src_f = addr_in[19:18];
  assign fmt_f = addr_in[11:10];
  assign grp_f = addr_in[19:16];
  assign opc_f = addr_in[15:12];
  assign r1_f = addr_in[9:6];
  assign r2_f = addr_in[5:2];
  assign word_xfer = ctrl_in[5:4] == `FPCD_XFER_WORD;
  assign store_xfer = ctrl_in[6];
  // Normal state when control bit 6 set
  assign priv_ok = !ctrl_in[1];

  // Decode operation and operand lengths
  always_comb
  begin
    op_nxt = FPCD_BAD;
    lng_src = 1'b0;
    lng_dst = 1'b0;
    if (addr_in[23:20] != `FPCD_RSV_ZERO)
    begin
      op_nxt = FPCD_BAD;
    end
    else if (src_f == `FPCD_SRC_RSV)
    begin
      op_nxt = FPCD_BAD;
    end
    else if (fmt_f == `FPCD_FMT_SHORT ||
             fmt_f == `FPCD_FMT_LONG)
    begin
      lng_src = fmt_f == `FPCD_FMT_LONG;
      lng_dst = fmt_f == `FPCD_FMT_LONG;
      case (opc_f)
        `FPCD_OP_ABS: op_nxt = FPCD_MAG;
        `FPCD_OP_ADD: op_nxt = FPCD_SUM;
        `FPCD_OP_CMP: op_nxt = FPCD_CMP;
        `FPCD_OP_COPY: op_nxt = FPCD_MOVE;
        `FPCD_OP_DIV: op_nxt = FPCD_QUOT;
        default: op_nxt = FPCD_BAD;
      endcase
    end
    else if (fmt_f == `FPCD_FMT_CVT)
    begin
      case (opc_f)
        `FPCD_CV_S2L:
        begin
          op_nxt = FPCD_WIDEN;
          lng_dst = 1'b1;
        end
        `FPCD_CV_W2S: op_nxt = FPCD_I2S;
        `FPCD_CV_W2L:
        begin
          op_nxt = FPCD_I2L;
          lng_dst = 1'b1;
        end
        `FPCD_CV_FLR: op_nxt = FPCD_FLOOR;
        default: op_nxt = FPCD_BAD;
      endcase
    end
    else
    begin
      if (opc_f == `FPCD_CV_L2S)
      begin
        op_nxt = FPCD_NARROW;
        lng_src = 1'b1;
      end
    end
  end

  // Group bits 12-15 must match the operation class
  logic grp_ok;
  always_comb
  begin
    grp_ok = 1'b0;
    if (fmt_f == `FPCD_FMT_CVT || fmt_f == `FPCD_FMT_CVT_LS)
    begin
      if (grp_f[1:0] != `FPCD_GRP_CVT)
      begin
        grp_ok = 1'b0;
      end
      else if (grp_f[3:2] == `FPCD_SRC_NONE)
      begin
        grp_ok = 1'b1;
      end
      else if (grp_f[3:2] == `FPCD_SRC_OP1)
      begin
        grp_ok = 1'b1;
      end
    end
    else
    begin
      grp_ok = grp_f[1:0] == `FPCD_GRP_ARITH;
    end
  end

  // Long selectors need lowest bit zero; compare ignores low two bits
  assign sel_ok = !((lng_src && r1_f[0]) ||
                    (lng_dst && op_nxt != FPCD_CMP && r2_f[0]) ||
                    (lng_dst && op_nxt == FPCD_CMP && r2_f[0]));
  assign legal = op_nxt != FPCD_BAD && sel_ok && word_xfer && store_xfer;

  // Supervisor-only encodings are outside this decoder's set
  logic needs_su;
  assign needs_su = 1'b0;

  // Command dispatched at this edge
  logic take_ok;
  assign take_ok = is_cmd && legal && grp_ok &&
                   (priv_ok || !needs_su);

  // Selectors and routing for the command on the channel
  logic [3:0] op1_sel_nxt;
  logic [3:0] op2_sel_nxt;
  logic [3:0] imm_sel_nxt;
  fpcd_imm_t imm_route_nxt;
  always_comb
  begin
    op1_sel_nxt = r1_f;
    op2_sel_nxt = r2_f;
    if (lng_src)
    begin
      op1_sel_nxt = {r1_f[3:1], 1'b0};
    end
    if (lng_dst)
    begin
      op2_sel_nxt = {r2_f[3:1], 1'b0};
    end
    case (src_f)
      `FPCD_SRC_OP1: imm_route_nxt = FPCD_IMM_OP1;
      `FPCD_SRC_OP2: imm_route_nxt = FPCD_IMM_OP2;
      default: imm_route_nxt = FPCD_IMM_NONE;
    endcase
    // Immediate lands in even (high) register of a long pair
    if (src_f == `FPCD_SRC_OP2)
    begin
      imm_sel_nxt = op2_sel_nxt;
    end
    else
    begin
      imm_sel_nxt = op1_sel_nxt;
    end
  end

  // Dispatch strobes, one cycle each
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_valid_out <= 1'b0;
      imm_wr_out <= 1'b0;
      result_wr_out <= 1'b0;
      cc_wr_out <= 1'b0;
    end
    else if (ce_in)
    begin
      cmd_valid_out <= take_ok;
      imm_wr_out <= take_ok && src_f != `FPCD_SRC_NONE;
      result_wr_out <= take_ok && op_nxt != FPCD_CMP;
      cc_wr_out <= take_ok && op_nxt == FPCD_CMP;
    end
  end

  // Operation and operand lengths, held until the next command
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      op_out <= FPCD_NOP;
      src_long_out <= 1'b0;
      dst_long_out <= 1'b0;
    end
    else if (ce_in && take_ok)
    begin
      op_out <= op_nxt;
      src_long_out <= lng_src;
      dst_long_out <= lng_dst;
    end
  end

  // Register selectors and immediate routing
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      op1_sel_out <= 4'h0;
      op2_sel_out <= 4'h0;
      imm_sel_out <= 4'h0;
      imm_route_out <= FPCD_IMM_NONE;
    end
    else if (ce_in && take_ok)
    begin
      op1_sel_out <= op1_sel_nxt;
      op2_sel_out <= op2_sel_nxt;
      imm_sel_out <= imm_sel_nxt;
      imm_route_out <= imm_route_nxt;
    end
  end

  // Immediate data word
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      imm_data_out <= 32'h0000_0000;
    end
    else if (ce_in && is_cmd && src_f != `FPCD_SRC_NONE)
    begin
      imm_data_out <= data_in;
    end
  end

  // Exception capture of the last command
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      exception_capture_reg_out <= 32'h0000_0000;
    end
    else if (ce_in && is_cmd)
    begin
      // Control byte in 0-7 with bit 7 zero, command bits 8-31
      exception_capture_reg_out <= {ctrl_in[7:1], 1'b0,
                                    addr_in[23:0]};
    end
  end

  // Exception report
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      exc_out <= 1'b0;
      exc_type_out <= 3'h0;
    end
    else if (ce_in)
    begin
      exc_out <= 1'b0;
      if (is_cmd)
      begin
        if (!(legal && grp_ok))
        begin
          exc_out <= 1'b1;
          exc_type_out <= `FPCD_EXC_ILLEGAL;
        end
        else if (needs_su && !priv_ok)
        begin
          exc_out <= 1'b1;
          exc_type_out <= `FPCD_EXC_PRIV;
        end
        else
        begin
          exc_type_out <= 3'h0;
        end
      end
    end
  end
endmodule

// file: verif/fpcd_decoder_chk.sv
// Port checker for the coprocessor command decoder.
// Assumes the decoder package is compiled first; bound at the foot.
module fpcd_chk
  import fpcd_pkg::*;
(
  // Decoder ports
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic xfer_valid_in,
  input wire logic [31:0] addr_in,
  input wire logic [7:0] ctrl_in,
  input wire logic [31:0] data_in,
  input wire logic cmd_valid_out,
  input wire fpcd_op_t op_out,
  input wire fpcd_imm_t imm_route_out,
  input wire logic [31:0] imm_data_out,
  input wire logic dst_long_out,
  input wire logic [3:0] op1_sel_out,
  input wire logic [3:0] op2_sel_out,
  input wire logic [3:0] imm_sel_out,
  input wire logic imm_wr_out,
  input wire logic result_wr_out,
  input wire logic cc_wr_out,
  input wire logic exc_out,
  input wire logic [2:0] exc_type_out,
  input wire logic [31:0] exception_capture_reg_out
);
  logic take;
  assign take = ce_in && xfer_valid_in && addr_in[31:24] == 8'hff;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_take_answer: assert property (take |=> cmd_valid_out != exc_out)
    else $error("taken command gave no single answer");
  a_idle_quiet: assert property (ce_in && !take |=>
    !cmd_valid_out && !exc_out) else $error("answer without command");
  a_word_only: assert property (take && ctrl_in[5:4] != 2'b10 |=>
    exc_out && exc_type_out == 3'h7) else $error("short transfer taken");
  a_route_rsv: assert property (take && addr_in[19:18] == 2'b11 |=>
    exc_out && !cmd_valid_out) else $error("reserved routing taken");
  a_capture_fmt: assert property (take |=> exception_capture_reg_out ==
    ({$past(ctrl_in) & 8'hfe, 24'h0} | ($past(addr_in) & 32'h00ff_ffff)))
    else $error("capture register wrong");
  a_imm_data: assert property (take && addr_in[19:18] != 2'b00 |=>
    !cmd_valid_out || imm_data_out == $past(data_in))
    else $error("immediate word wrong");
  a_imm_target: assert property (cmd_valid_out && imm_wr_out |->
    imm_sel_out == (imm_route_out == FPCD_IMM_OP1 ? op1_sel_out : op2_sel_out))
    else $error("immediate sent to wrong register");
  a_cmp_nowrite: assert property (cmd_valid_out && op_out == FPCD_CMP |->
    cc_wr_out && !result_wr_out) else $error("compare wrote a register");
  a_long_even: assert property (cmd_valid_out && dst_long_out |->
    !op2_sel_out[0]) else $error("long result on odd register");
  cover property (cmd_valid_out && op_out == FPCD_CMP);
  cover property (exc_out);
  cover property (cmd_valid_out && dst_long_out && imm_wr_out);
endmodule

bind fpcd_decoder fpcd_chk u_chk (.clk_in, .arst_n_in, .ce_in,
  .xfer_valid_in, .addr_in, .ctrl_in, .data_in, .cmd_valid_out, .op_out,
  .imm_route_out, .imm_data_out, .dst_long_out, .op1_sel_out, .op2_sel_out,
  .imm_sel_out, .imm_wr_out, .result_wr_out, .cc_wr_out, .exc_out,
  .exc_type_out, .exception_capture_reg_out);

// file: verif/fpcd_host.sv
// Host model issuing command transfers on the processor channel.
// Assumes the caller stands at a falling clock edge.
module fpcd_host (
  // Channel
  input wire logic clk_in,
  output logic xfer_valid_out,
  output logic [31:0] addr_out,
  output logic [7:0] ctrl_out,
  output logic [31:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {xfer_valid_out, addr_out, ctrl_out, data_out} = '0;
  end
  // Held through the taking edge; callers also send reserved and illegal codes
  task send(input logic [31:0] a, input logic [7:0] c, input logic [31:0] d);
    xfer_valid_out = 1;
    addr_out = a;
    ctrl_out = c;
    data_out = d;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask
  // Released address and data lines show no stale value; control keeps its value
  task idle;
    xfer_valid_out = 0;
    addr_out = ~addr_out;
    data_out = ~data_out;
    @(negedge clk_in);
  endtask
endmodule

// file: verif/test_fp_command_decoder.sv
// Self-checking bench for the command decoder.
// Assumes the host model and checker are compiled alongside.
module test_fp_command_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  import fpcd_pkg::*;
  logic clk_in, arst_n_in, ce_in, xfer_valid_in, cmd_valid_out, exc_out;
  logic src_long_out, dst_long_out, imm_wr_out, result_wr_out, cc_wr_out;
  logic [31:0] addr_in, data_in, imm_data_out, exception_capture_reg_out;
  logic [7:0] ctrl_in;
  logic [3:0] op1_sel_out, op2_sel_out, imm_sel_out;
  logic [2:0] exc_type_out;
  fpcd_op_t op_out;
  fpcd_imm_t imm_route_out;
  int errors, total_checks, cycles;
  fpcd_host host (.clk_in, .xfer_valid_out(xfer_valid_in),
    .addr_out(addr_in), .ctrl_out(ctrl_in), .data_out(data_in));
  fpcd_decoder uut (.clk_in, .arst_n_in, .ce_in, .xfer_valid_in, .addr_in,
    .ctrl_in, .data_in, .cmd_valid_out, .op_out, .imm_route_out,
    .imm_data_out, .src_long_out, .dst_long_out, .op1_sel_out, .op2_sel_out,
    .imm_sel_out, .imm_wr_out, .result_wr_out, .cc_wr_out, .exc_out,
    .exc_type_out, .exception_capture_reg_out);
  always #25 clk_in = ~clk_in;
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 500)
    begin
      errors++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      finish_test;
    end
  end
  task chk(input string n, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task issue_cmd(input logic [3:0] pre, op, input logic [1:0] fmt,
    input logic [3:0] r1, r2, input fpcd_op_t eop, input logic sl, dl);
    logic [31:0] a;
    a = {8'hff, 4'h0, pre, op, fmt, r1, r2, {2{eop == FPCD_CMP}}};
    host.send(a, 8'h67, a ^ 32'hc3a5_0f96);
    chk("dispatch", {2'b10, eop, pre[3:2], sl, dl, r1, r2, pre[3:2] != 0,
      eop != FPCD_CMP, eop == FPCD_CMP}, {cmd_valid_out, exc_out, op_out,
      imm_route_out, src_long_out, dst_long_out, op1_sel_out, op2_sel_out,
      imm_wr_out, result_wr_out, cc_wr_out});
    if (pre[3:2] != 0)
      chk("immediate", {pre[3] ? r1 : r2, a ^ 32'hc3a5_0f96},
        {imm_sel_out, imm_data_out});
    chk("capture", {7'h33, 1'b0, a[23:0]}, exception_capture_reg_out);
  endtask
  task t_dispatch;
    issue_cmd(4'h9, 4'hd, 2'h1, 4'h3, 4'h5, FPCD_MAG, 0, 0);
    issue_cmd(4'h9, 4'hd, 2'h0, 4'h4, 4'h6, FPCD_MAG, 1, 1);
    issue_cmd(4'h5, 4'h0, 2'h1, 4'h2, 4'h7, FPCD_SUM, 0, 0);
    issue_cmd(4'h9, 4'h0, 2'h0, 4'h8, 4'ha, FPCD_SUM, 1, 1);
    issue_cmd(4'h1, 4'h2, 2'h1, 4'h1, 4'he, FPCD_CMP, 0, 0);
    issue_cmd(4'h9, 4'h2, 2'h0, 4'h6, 4'h0, FPCD_CMP, 1, 1);
    issue_cmd(4'h0, 4'h6, 2'h3, 4'h9, 4'ha, FPCD_WIDEN, 0, 1);
    issue_cmd(4'h8, 4'h5, 2'h2, 4'hc, 4'hb, FPCD_NARROW, 1, 0);
    issue_cmd(4'h0, 4'h1, 2'h3, 4'hd, 4'h0, FPCD_I2S, 0, 0);
    issue_cmd(4'h8, 4'h0, 2'h3, 4'h1, 4'h8, FPCD_I2L, 0, 1);
    issue_cmd(4'h1, 4'h1, 2'h0, 4'he, 4'h2, FPCD_MOVE, 1, 1);
    issue_cmd(4'h5, 4'h8, 2'h1, 4'h6, 4'h3, FPCD_QUOT, 0, 0);
    issue_cmd(4'h8, 4'hf, 2'h3, 4'h7, 4'h4, FPCD_FLOOR, 0, 0);
  endtask
  task refuse(input logic [31:0] a, input logic [7:0] c, input logic e);
    host.send(a, c, 32'h1234_5678);
    chk("refusal", {1'b0, e}, {cmd_valid_out, exc_out});
    if (e)
      chk("exc_type", 3'h7, exc_type_out);
  endtask
  task t_refusals;
    refuse(32'hfe01_d564, 8'h67, 0);
    refuse(32'hff11_d564, 8'h67, 1);
    refuse(32'hff01_d564, 8'h27, 1);
    refuse(32'hff01_d564, 8'h77, 1);
    refuse(32'hff01_0150, 8'h67, 1);
    refuse(32'hff0d_0554, 8'h67, 1);
  endtask
  task t_freeze;
    host.idle;
    ce_in = 0;
    host.send(32'hff01_d564, 8'h67, 32'h0);
    ce_in = 1;
    host.idle;
    chk("frozen", 2'b00, {cmd_valid_out, exc_out});
    chk("frozen_capture", {7'h33, 1'b0, 24'h0d_0554},
      exception_capture_reg_out);
  endtask
  initial
  begin
    {clk_in, arst_n_in, errors, total_checks, cycles} = '0;
    ce_in = 1;
    repeat (16) @(negedge clk_in);
    chk("reset", 0, {cmd_valid_out, exc_out, op_out, exception_capture_reg_out});
    arst_n_in = 1;
    t_dispatch;
    t_refusals;
    t_freeze;
    finish_test;
  end
endmodule
